/* logic/udsp_defs.svh */
/*
  Constants of the user-defined serial packet sequencer: register map,
  field positions of table words, interrupt bits and timing figures.
  Assumes it is included by bare name after the type package.
*/
`ifndef UDSP_DEFS_SVH
`define UDSP_DEFS_SVH

`define UDSP_A_CTRL    12'h000
`define UDSP_A_STAT    12'h001
`define UDSP_A_ISTAT   12'h002
`define UDSP_A_IMASK   12'h003
`define UDSP_A_NGRP    12'h004
`define UDSP_B_GRP     12'h010
`define UDSP_B_DREG    12'h100
`define UDSP_B_CMD     12'h200
`define UDSP_B_PCFG    12'h300
`define UDSP_B_SEG     12'h400

`define UDSP_CTRL_START 0
`define UDSP_CTRL_STOP  1

`define UDSP_IRQ_DONE  0
`define UDSP_IRQ_ABORT 1
`define UDSP_IRQ_FAIL  2
`define UDSP_IRQ_TMO   3

`define UDSP_SEG_CLS   0
`define UDSP_SEG_FMT   2
`define UDSP_SEG_VAR   4
`define UDSP_SEG_FN    5
`define UDSP_SEG_WIDE  7
`define UDSP_SEG_ALG   8
`define UDSP_SEG_VAL   16
`define UDSP_SEG_REG   24
`define UDSP_SEG_LEN   16

`define UDSP_CMD_TYPE  0
`define UDSP_CMD_TXP   2
`define UDSP_CMD_RXP   5
`define UDSP_CMD_SACT  8
`define UDSP_CMD_FACT  10
`define UDSP_CMD_SGO   12
`define UDSP_CMD_FGO   16
`define UDSP_CMD_RETRY 0
`define UDSP_CMD_REP   8
`define UDSP_CMD_WAIT  0
`define UDSP_CMD_TMO   16

`define UDSP_PCFG_INIT 0
`define UDSP_PCFG_NSEG 16

`define UDSP_MAX_SEG   7'd64
`define UDSP_CODE_MASK 8'h1f
`define UDSP_CRC_POLY  16'ha001
`define UDSP_CLK_NS    8
`define UDSP_MS_NS     1000000
`define UDSP_TMO_MIN   16'd50

`endif

/* logic/udsp_pkg.sv */
/*
  Types of the user-defined serial packet sequencer.
  Assumes nothing of its surroundings.
*/
package udsp_pkg;
  typedef enum logic [1:0] {CLS_MSG, CLS_ADDR, CLS_LEN, CLS_CKS} udsp_cls_t;
  typedef enum logic [1:0] {FMT_NULL, FMT_HEX, FMT_ASCII, FMT_CODE} udsp_fmt_t;
  typedef enum logic [1:0] {FN_READ, FN_WRITE, FN_WILD, FN_RSVD} udsp_fn_t;
  typedef enum logic [1:0] {CT_SEND, CT_RECV, CT_SR, CT_RSVD} udsp_ctype_t;
  typedef enum logic [1:0] {ACT_NEXT, ACT_GOTO, ACT_END, ACT_RSVD} udsp_act_t;
  typedef enum {ST_IDLE, ST_LOAD, ST_SEG, ST_TX, ST_RX, ST_WAIT} udsp_state_t;
endpackage : udsp_pkg

/* logic/udsp_conv.sv */
/*
  Byte format converter: ASCII digit to hex value and hex value to ASCII.
  Purely combinational; the caller registers what it keeps.
*/
`timescale 1ns/1ps
module udsp_conv (
  input  wire logic [7:0] byte_in,
  output logic      [7:0] hex_out,
  output logic      [7:0] asc_out
);
  always_comb
  begin
    hex_out = 8'h00; // [R5]
    if (byte_in >= 8'h30 && byte_in <= 8'h39)
      hex_out = byte_in - 8'h30;
    else if (byte_in >= 8'h41 && byte_in <= 8'h46)
      hex_out = byte_in - 8'h37;
    else if (byte_in >= 8'h61 && byte_in <= 8'h66)
      hex_out = byte_in - 8'h57;
  end

  always_comb
  begin
    asc_out = 8'h00; // [R6]
    if (byte_in <= 8'h09)
      asc_out = byte_in + 8'h30;
    else if (byte_in <= 8'h0f)
      asc_out = byte_in + 8'h37;
  end
endmodule : udsp_conv

/* logic/udsp_cksum.sv */
/*
  Running checksum of one packet: 16-bit byte sum and reflected CRC-16,
  both kept in parallel so the checksum segment may pick either.
  Assumes clear and add never come in the same cycle.
*/
`timescale 1ns/1ps
`include "udsp_defs.svh"
module udsp_cksum (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        clr_in,
  input  wire logic [15:0] init_in,
  input  wire logic        add_in,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] sum_out,
  output logic      [15:0] crc_out
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `UDSP_CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_step

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sum_out <= 16'h0000;
      crc_out <= 16'h0000;
    end
    else if (clr_in)
    begin
      sum_out <= init_in; // [R9]
      crc_out <= init_in;
    end
    else if (add_in)
    begin
      sum_out <= sum_out + {8'h00, byte_in}; // [R19]
      crc_out <= crc_step(crc_out, byte_in); // [R19]
    end
  end
endmodule : udsp_cksum

/* logic/udsp_seq.sv */
/*
  User-defined serial packet sequencer: packet tables, command tables,
  group order, the command state machine and the software register port.
  Assumes a byte UART on the same clock: tx bytes leave on a valid/ready
  handshake, rx bytes arrive as one-cycle valid pulses.
*/
`timescale 1ns/1ps
`include "udsp_defs.svh"

// Summary of operation
// R1: Each packet holds up to 64 ordered segments, each with class and format.
// R2: Any number of messages, at most one address, length and checksum.
// R3: Constant segments go out as hex, ASCII or masked control code.
// R4: Null format passes variable data unchanged.
// R5: Hex format turns ASCII digits into values, anything else into zero.
// R6: ASCII format turns values into characters, unrepresentable ones into zero.
// R7: Transmit variables only read; receive variables compare, write or match anything.
// R8: Length is one or two bytes, hex or ASCII encoded.
// R9: Checksum starts from a set initial value; reverse swaps its two bytes.
// R10: Commands send, receive, or send then receive a defined packet.
// R11: Commands run in ascending number unless an action redirects.
// R12: On success go next, jump, or end the sequence.
// R13: On failure go next, jump, or abort the sequence.
// R14: A failed command is retried up to 0 to 255 times.
// R15: A successful command is repeated 0 to 255 extra times.
// R16: Wait 0 to 65535 ms between commands, zero meaning none.
// R17: No reply within 50 to 65535 ms fails the command.
// R18: Groups run one after another, each with its own command sequence.
// R19: Checksum offers byte sum and CRC-16, chosen by the checksum segment.
module udsp_seq
  import udsp_pkg::*;
#(
  parameter int NGRP   = 4,
  parameter int MS_CYC = `UDSP_MS_NS / `UDSP_CLK_NS
)(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic      [7:0]  tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  output logic             busy_out,
  output logic             irq_out
);
  // Tables have no reset; software loads them before starting.
  logic [31:0] seg_mem [512];
  logic [31:0] cmd_mem [64];
  logic [22:0] pcfg    [8];
  logic [7:0]  dreg    [64];
  logic [3:0]  gtab    [NGRP];
  logic [2:0]  ngrp;
  logic [3:0]  imask;
  logic [3:0]  istat;

  udsp_state_t state;
  logic [1:0]  grp;
  logic [3:0]  cmd;
  logic [2:0]  pkt;
  logic        is_rx;
  logic [6:0]  sidx;
  logic        bsel;
  logic [2:0]  seen;
  logic [7:0]  try_cnt;
  logic [7:0]  rep_cnt;
  logic [15:0] wait_ms;
  logic [31:0] pre;
  logic [15:0] ms_cnt;

  function automatic logic in_rng(input logic [11:0] a, input logic [11:0] base,
                                  input logic [11:0] n);
    return (a >= base) && (a < base + n);
  endfunction : in_rng

  // Command words of the current command.
  logic [31:0] cw0;
  logic [31:0] cw1;
  logic [31:0] cw2;
  udsp_ctype_t c_type;
  udsp_act_t   c_sact;
  udsp_act_t   c_fact;
  logic [15:0] c_tmo;
  assign cw0    = cmd_mem[{cmd, 2'd0}];
  assign cw1    = cmd_mem[{cmd, 2'd1}];
  assign cw2    = cmd_mem[{cmd, 2'd2}];
  assign c_type = udsp_ctype_t'(cw0[`UDSP_CMD_TYPE +: 2]); // [R10]
  assign c_sact = udsp_act_t'(cw0[`UDSP_CMD_SACT +: 2]);
  assign c_fact = udsp_act_t'(cw0[`UDSP_CMD_FACT +: 2]);
  // A timeout below the floor is raised to it.
  assign c_tmo  = (cw2[`UDSP_CMD_TMO +: 16] < `UDSP_TMO_MIN) ? `UDSP_TMO_MIN
                : cw2[`UDSP_CMD_TMO +: 16]; // [R17]

  // Current segment and its fields.
  logic [31:0] seg;
  udsp_cls_t   cls;
  udsp_fmt_t   fmt;
  udsp_fn_t    fn;
  logic        isvar;
  logic        wide;
  logic [6:0]  nseg;
  logic [15:0] lenv;
  logic [3:0]  lnib;
  logic [7:0]  var_raw;
  logic [7:0]  v_hex;
  logic [7:0]  v_asc;
  logic [7:0]  r_hex;
  logic [7:0]  r_asc;
  logic [15:0] ck_sum;
  logic [15:0] ck_crc;
  logic [15:0] ck;
  logic [15:0] ckw;
  logic [7:0]  seg_byte;
  assign seg     = seg_mem[{pkt, sidx[5:0]}]; // [R1]
  assign cls     = udsp_cls_t'(seg[`UDSP_SEG_CLS +: 2]);
  assign fmt     = udsp_fmt_t'(seg[`UDSP_SEG_FMT +: 2]);
  assign fn      = udsp_fn_t'(seg[`UDSP_SEG_FN +: 2]);
  assign isvar   = seg[`UDSP_SEG_VAR];
  assign wide    = seg[`UDSP_SEG_WIDE];
  assign nseg    = pcfg[pkt][`UDSP_PCFG_NSEG +: 7];
  assign lenv    = seg[`UDSP_SEG_LEN +: 16];
  assign lnib    = (wide && !bsel) ? lenv[7:4] : lenv[3:0];
  assign var_raw = dreg[seg[`UDSP_SEG_REG +: 6]];
  assign ck      = seg[`UDSP_SEG_ALG] ? ck_crc : ck_sum; // [R19]
  assign ckw     = wide ? {ck[7:0], ck[15:8]} : ck; // [R9]

  // One converter serves variables and ASCII length digits, one serves rx data.
  udsp_conv u_conv_seg (
    .byte_in (cls == CLS_LEN ? {4'h0, lnib} : var_raw),
    .hex_out (v_hex),
    .asc_out (v_asc)
  );
  udsp_conv u_conv_rx (
    .byte_in (rx_data_in),
    .hex_out (r_hex),
    .asc_out (r_asc)
  );

  always_comb
  begin
    seg_byte = 8'h00;
    case (cls)
      CLS_LEN:
        if (fmt == FMT_ASCII)
          seg_byte = v_asc; // [R8]
        else
          seg_byte = (wide && !bsel) ? lenv[15:8] : lenv[7:0]; // [R8]
      CLS_CKS:
        seg_byte = bsel ? ckw[7:0] : ckw[15:8];
      default:
        if (!isvar)
          seg_byte = (fmt == FMT_CODE) ? (seg[`UDSP_SEG_VAL +: 8] & `UDSP_CODE_MASK)
                   : seg[`UDSP_SEG_VAL +: 8]; // [R3]
        else
          case (fmt)
            FMT_HEX:   seg_byte = v_hex; // [R5]
            FMT_ASCII: seg_byte = v_asc; // [R6]
            default:   seg_byte = var_raw; // [R4]
          endcase
    endcase
  end

  // Per-segment decisions.
  logic last_byte;
  logic dup_err;
  logic nseg_bad;
  logic rx_take;
  logic rx_wr;
  logic pkt_end;
  logic to_rx;
  logic cmd_ok;
  logic cmd_bad;
  logic rx_hit;
  logic tmo;
  logic adv;
  assign last_byte = (cls == CLS_CKS || (cls == CLS_LEN && wide)) ? bsel : 1'b1;
  assign dup_err   = !bsel && ((cls == CLS_ADDR && seen[0]) || (cls == CLS_LEN && seen[1])
                   || (cls == CLS_CKS && seen[2])); // [R2]
  assign nseg_bad  = nseg > `UDSP_MAX_SEG; // [R1]
  // Writes and wildcards accept any byte; everything else must match.
  assign rx_wr     = isvar && (cls == CLS_MSG || cls == CLS_ADDR) && fn == FN_WRITE;
  assign rx_take   = rx_wr || (isvar && (cls == CLS_MSG || cls == CLS_ADDR) && fn == FN_WILD)
                   || rx_data_in == seg_byte; // [R7]
  assign pkt_end   = state == ST_SEG && !nseg_bad && sidx == nseg;
  assign to_rx     = pkt_end && !is_rx && c_type == CT_SR; // [R10]
  assign cmd_ok    = pkt_end && !to_rx;
  assign rx_hit    = state == ST_RX && rx_valid_in;
  assign tmo       = state == ST_RX && !rx_valid_in && ms_cnt >= c_tmo; // [R17]
  assign cmd_bad   = (state == ST_SEG && (nseg_bad || (!pkt_end && dup_err)))
                   || (rx_hit && !rx_take) || tmo;
  assign adv       = (state == ST_TX && tx_ready_in) || (rx_hit && rx_take);

  udsp_cksum u_cksum (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .clr_in  (state == ST_LOAD || to_rx),
    .init_in (pcfg[pkt][`UDSP_PCFG_INIT +: 16]),
    .add_in  (adv && cls != CLS_CKS),
    .byte_in (is_rx ? rx_data_in : seg_byte),
    .sum_out (ck_sum),
    .crc_out (ck_crc)
  );

  // Where the sequence goes once a command has finished.
  logic       rerun;
  logic       seq_end;
  logic       seq_abort;
  logic [3:0] nx_cmd;
  always_comb
  begin
    rerun     = 1'b0;
    seq_end   = 1'b0;
    seq_abort = 1'b0;
    nx_cmd    = cmd + 4'd1; // [R11]
    if (cmd_ok)
    begin
      if (rep_cnt < cw1[`UDSP_CMD_REP +: 8])
        rerun = 1'b1; // [R15]
      else if (c_sact == ACT_GOTO)
        nx_cmd = cw0[`UDSP_CMD_SGO +: 4]; // [R12]
      else if (c_sact != ACT_NEXT)
        seq_end = 1'b1; // [R12]
    end
    else if (cmd_bad)
    begin
      if (try_cnt < cw1[`UDSP_CMD_RETRY +: 8])
        rerun = 1'b1; // [R14]
      else if (c_fact == ACT_GOTO)
        nx_cmd = cw0[`UDSP_CMD_FGO +: 4]; // [R13]
      else if (c_fact != ACT_NEXT)
        seq_abort = 1'b1; // [R13]
    end
  end

  logic start_req;
  logic stop_req;
  logic last_grp;
  assign start_req = reg_wr_in && reg_addr_in == `UDSP_A_CTRL && reg_wdata_in[`UDSP_CTRL_START];
  assign stop_req  = reg_wr_in && reg_addr_in == `UDSP_A_CTRL && reg_wdata_in[`UDSP_CTRL_STOP];
  assign last_grp  = {1'b0, grp} + 3'd1 >= ngrp;

  // Command state machine.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state        <= ST_IDLE;
      grp          <= 2'd0;
      cmd          <= 4'd0;
      pkt          <= 3'd0;
      is_rx        <= 1'b0;
      sidx         <= 7'd0;
      bsel         <= 1'b0;
      seen         <= 3'd0;
      try_cnt      <= 8'd0;
      rep_cnt      <= 8'd0;
      wait_ms      <= 16'd0;
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
    end
    else if (stop_req)
    begin
      state        <= ST_IDLE;
      tx_valid_out <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (start_req)
          begin
            grp     <= 2'd0;
            cmd     <= gtab[0]; // [R18]
            try_cnt <= 8'd0;
            rep_cnt <= 8'd0;
            state   <= ST_LOAD;
          end
        ST_LOAD:
        begin
          is_rx <= c_type == CT_RECV;
          pkt   <= (c_type == CT_RECV) ? cw0[`UDSP_CMD_RXP +: 3] : cw0[`UDSP_CMD_TXP +: 3];
          sidx  <= 7'd0;
          bsel  <= 1'b0;
          seen  <= 3'd0;
          state <= ST_SEG;
        end
        ST_SEG:
          if (to_rx)
          begin
            is_rx <= 1'b1;
            pkt   <= cw0[`UDSP_CMD_RXP +: 3];
            sidx  <= 7'd0;
            bsel  <= 1'b0;
            seen  <= 3'd0;
          end
          else if (!(cmd_ok || cmd_bad))
          begin
            if (is_rx)
              state <= ST_RX;
            else
            begin
              tx_data_out  <= seg_byte;
              tx_valid_out <= 1'b1;
              state        <= ST_TX;
            end
          end
        ST_TX:
          if (tx_ready_in)
          begin
            tx_valid_out <= 1'b0;
            state        <= ST_SEG;
          end
        ST_RX:
          if (rx_hit && rx_take)
            state <= ST_SEG;
        ST_WAIT:
          if (ms_cnt >= wait_ms)
            state <= ST_LOAD; // [R16]
        default:
          state <= ST_IDLE;
      endcase

      if (adv)
      begin
        bsel <= !last_byte;
        if (last_byte)
        begin
          sidx <= sidx + 7'd1;
          if (cls != CLS_MSG)
            seen[cls - CLS_ADDR] <= 1'b1; // [R2]
        end
      end

      if (cmd_ok || cmd_bad)
      begin
        wait_ms <= cw2[`UDSP_CMD_WAIT +: 16]; // [R16]
        state   <= ST_WAIT;
        if (rerun)
        begin
          try_cnt <= cmd_bad ? try_cnt + 8'd1 : 8'd0;
          rep_cnt <= cmd_ok ? rep_cnt + 8'd1 : rep_cnt;
        end
        else
        begin
          try_cnt <= 8'd0;
          rep_cnt <= 8'd0;
          cmd     <= nx_cmd;
          if (seq_abort || (seq_end && last_grp))
            state <= ST_IDLE;
          else if (seq_end)
          begin
            grp <= grp + 2'd1;
            cmd <= gtab[grp + 2'd1]; // [R18]
          end
        end
      end
    end
  end

  // Millisecond timer for the reply timeout and the wait between commands.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || state == ST_LOAD || to_rx || cmd_ok || cmd_bad)
    begin
      pre    <= 32'd0;
      ms_cnt <= 16'd0;
    end
    else if (pre == 32'(MS_CYC - 1))
    begin
      pre    <= 32'd0;
      ms_cnt <= (ms_cnt == 16'hffff) ? ms_cnt : ms_cnt + 16'd1;
    end
    else
      pre <= pre + 32'd1;
  end

  // Table writes; a received write segment stores into the data registers.
  always_ff @(posedge clk_in)
  begin
    if (rx_hit && rx_take && rx_wr)
      dreg[seg[`UDSP_SEG_REG +: 6]] <= (fmt == FMT_HEX) ? r_hex
                                     : (fmt == FMT_ASCII) ? r_asc : rx_data_in; // [R7]
    else if (reg_wr_in && in_rng(reg_addr_in, `UDSP_B_DREG, 12'd64))
      dreg[reg_addr_in[5:0]] <= reg_wdata_in[7:0];
    if (reg_wr_in && in_rng(reg_addr_in, `UDSP_B_SEG, 12'd512))
      seg_mem[reg_addr_in[8:0]] <= reg_wdata_in;
    if (reg_wr_in && in_rng(reg_addr_in, `UDSP_B_CMD, 12'd64))
      cmd_mem[reg_addr_in[5:0]] <= reg_wdata_in;
    if (reg_wr_in && in_rng(reg_addr_in, `UDSP_B_PCFG, 12'd8))
      pcfg[reg_addr_in[2:0]] <= reg_wdata_in[22:0];
    if (reg_wr_in && in_rng(reg_addr_in, `UDSP_B_GRP, 12'(NGRP)))
      gtab[reg_addr_in[1:0]] <= reg_wdata_in[3:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ngrp  <= 3'd1;
      imask <= 4'h0;
    end
    else if (reg_wr_in && reg_addr_in == `UDSP_A_NGRP)
      ngrp <= reg_wdata_in[2:0];
    else if (reg_wr_in && reg_addr_in == `UDSP_A_IMASK)
      imask <= reg_wdata_in[3:0];
  end

  // Sticky events; a new event in the clearing cycle stays set.
  logic [3:0] ev;
  assign ev[`UDSP_IRQ_DONE]  = cmd_ok && !rerun && seq_end && last_grp;
  assign ev[`UDSP_IRQ_ABORT] = (cmd_bad && seq_abort) || (stop_req && state != ST_IDLE);
  assign ev[`UDSP_IRQ_FAIL]  = cmd_bad;
  assign ev[`UDSP_IRQ_TMO]   = tmo;
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      istat <= 4'h0;
    else if (reg_wr_in && reg_addr_in == `UDSP_A_ISTAT)
      istat <= (istat & ~reg_wdata_in[3:0]) | ev;
    else
      istat <= istat | ev;
  end
  assign irq_out  = |(istat & imask);
  assign busy_out = state != ST_IDLE;

  // Read data stands in the cycle after the strobe and is zero otherwise.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (reg_addr_in == `UDSP_A_STAT)
      rd_mux = {8'h00, try_cnt, 4'h0, 2'b00, grp, cmd, 3'b000, busy_out};
    else if (reg_addr_in == `UDSP_A_ISTAT)
      rd_mux = {28'h0, istat};
    else if (reg_addr_in == `UDSP_A_IMASK)
      rd_mux = {28'h0, imask};
    else if (reg_addr_in == `UDSP_A_NGRP)
      rd_mux = {29'h0, ngrp};
    else if (in_rng(reg_addr_in, `UDSP_B_GRP, 12'(NGRP)))
      rd_mux = {28'h0, gtab[reg_addr_in[1:0]]};
    else if (in_rng(reg_addr_in, `UDSP_B_DREG, 12'd64))
      rd_mux = {24'h0, dreg[reg_addr_in[5:0]]};
    else if (in_rng(reg_addr_in, `UDSP_B_CMD, 12'd64))
      rd_mux = cmd_mem[reg_addr_in[5:0]];
    else if (in_rng(reg_addr_in, `UDSP_B_PCFG, 12'd8))
      rd_mux = {9'h0, pcfg[reg_addr_in[2:0]]};
    else if (in_rng(reg_addr_in, `UDSP_B_SEG, 12'd512))
      rd_mux = seg_mem[reg_addr_in[8:0]];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || !reg_rd_in)
      reg_rdata_out <= 32'h0;
    else
      reg_rdata_out <= rd_mux;
  end
endmodule : udsp_seq

/* testbench/udsp_seq_monitor.sv */
/*
  Port checker of the serial packet sequencer.
  Assumes it is bound to udsp_seq by the bind at the foot of this file.
*/
`timescale 1ns/1ps
`include "udsp_defs.svh"
module udsp_seq_monitor (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_rdata_out,
  input  wire logic [7:0]  tx_data_out,
  input  wire logic        tx_valid_out,
  input  wire logic        tx_ready_in,
  input  wire logic        busy_out,
  input  wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic ctl;
  assign ctl = reg_wr_in && reg_addr_in == `UDSP_A_CTRL;
  // A stop may drop a pending byte, so it is left out of the hold check.
  tx_hold_a: assert property (
    tx_valid_out && !tx_ready_in && !(ctl && reg_wdata_in[`UDSP_CTRL_STOP])
    |=> tx_valid_out && $stable(tx_data_out)) else $error("tx byte not held");
  tx_gap_a: assert property (
    tx_valid_out && tx_ready_in |=> !tx_valid_out && $stable(tx_data_out))
    else $error("tx gap wrong");
  idle_quiet_a: assert property (
    !busy_out |-> !tx_valid_out) else $error("tx while idle");
  start_busy_a: assert property (
    ctl && reg_wdata_in[`UDSP_CTRL_START] && !reg_wdata_in[`UDSP_CTRL_STOP] && !busy_out
    |=> busy_out) else $error("start ignored");
  stat_busy_a: assert property (
    reg_rd_in && reg_addr_in == `UDSP_A_STAT |=> reg_rdata_out[0] == $past(busy_out))
    else $error("status busy wrong");
  irq_mask_a: assert property (
    reg_wr_in && reg_addr_in == `UDSP_A_IMASK && reg_wdata_in[3:0] == 4'h0 |=> !irq_out)
    else $error("masked irq high");
  rd_pulse_a: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("rdata outside read");
  unmapped_zero_a: assert property (
    reg_rd_in && reg_addr_in == 12'h005 |=> reg_rdata_out == 32'h0) else $error("unmapped read");
  cover property (ctl && reg_wdata_in[`UDSP_CTRL_START]);
  cover property (tx_valid_out && tx_ready_in);
  cover property ($rose(irq_out));
endmodule : udsp_seq_monitor

bind udsp_seq udsp_seq_monitor mon (.*);

/* testbench/udsp_link_model.sv */
/*
  Far-side serial device: takes tx bytes, optionally stalling, and plays back
  queued reply bytes spaced four cycles apart.
  Assumes the bench fills rsp_q while the sequencer waits for a reply.
*/
`timescale 1ns/1ps
module udsp_link_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  input  wire logic       slow_in,
  output logic            tx_ready_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out
);
  logic [7:0] got_q[$];
  logic [7:0] rsp_q[$];
  int         gap;
  initial
  begin
    tx_ready_out = 1'b0;
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    gap = 0;
  end
  // Outside a byte the data line toggles so a stale value is never mistaken.
  always @(posedge clk_in)
  begin
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
    gap <= gap + 1;
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
    if (rsp_q.size() != 0 && gap % 4 == 3)
    begin
      rx_data_out <= rsp_q.pop_front();
      rx_valid_out <= 1'b1;
    end
  end
endmodule : udsp_link_model

/* testbench/udsp_seq_test.sv */
/*
  Self-checking bench of the serial packet sequencer: register tasks,
  two sends, one timed-out receive and one receive that stores data.
  Assumes MS_CYC of 10 so one millisecond lasts ten cycles.
*/
`timescale 1ns/1ps
`include "udsp_defs.svh"
module udsp_seq_test;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  txd;
  logic [7:0]  rxd;
  logic        txv;
  logic        txr;
  logic        rxv;
  logic        busy;
  logic        irq;
  logic [31:0] v;
  logic [7:0]  exp_b[5] = '{8'h3a, 8'h5a, 8'h0d, 8'ha2, 8'h00};
  logic [7:0]  exp_c[6] = '{8'h33, 8'h35, 8'h0b, 8'h43, 8'h00, 8'h00};
  int          err_count = 0;
  int          cmp_count = 0;
  int          n;

  always #4 clk_in = ~clk_in;

  udsp_seq #(.NGRP(4), .MS_CYC(10)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(txr),
    .rx_data_in(rxd), .rx_valid_in(rxv), .busy_out(busy), .irq_out(irq));
  udsp_link_model m (.clk_in(clk_in), .tx_data_in(txd), .tx_valid_in(txv), .slow_in(slow),
    .tx_ready_out(txr), .rx_data_out(rxd), .rx_valid_out(rxv));

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge clk_in);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Starts the loaded group and counts cycles until the sequence ends.
  task automatic run(output int c);
    c = 0;
    wr(`UDSP_A_CTRL, 32'h1);
    while (busy !== 1'b0 && c < 3000)
    begin
      @(posedge clk_in);
      c++;
    end
    chk({31'h0, busy}, 32'h0);
  endtask : run

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #(8 * 20000);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(`UDSP_A_NGRP, v); chk(v, 32'h1);
    rd(`UDSP_A_STAT, v); chk(v, 32'h0);
    rd(12'h005, v); chk(v, 32'h0);
    wr(`UDSP_A_IMASK, 32'h0);
    wr(`UDSP_A_IMASK, 32'hf);
    // Send with one repeat, constant, plain variable, control code, reversed sum.
    wr(`UDSP_B_DREG, 32'h5a);
    wr(`UDSP_B_SEG, 32'h003a0000);
    wr(`UDSP_B_SEG + 12'h1, 32'h00000010);
    wr(`UDSP_B_SEG + 12'h2, 32'h008d000c);
    wr(`UDSP_B_SEG + 12'h3, 32'h00000083);
    wr(`UDSP_B_PCFG, 32'h00040001);
    wr(`UDSP_B_CMD, 32'h00000200);
    wr(`UDSP_B_CMD + 12'h1, 32'h00000100);
    wr(`UDSP_B_CMD + 12'h2, 32'h00320000);
    wr(`UDSP_B_GRP, 32'h0);
    slow <= 1'b1;
    run(n);
    slow <= 1'b0;
    chk(m.got_q.size(), 32'd10);
    for (int i = 0; i < 10; i++) chk({24'h0, m.got_q[i]}, {24'h0, exp_b[i % 5]});
    #1 chk({31'h0, irq}, 32'h1);
    @(posedge clk_in);
    rd(`UDSP_A_ISTAT, v); chk(v & 32'h1, 32'h1);
    wr(`UDSP_A_ISTAT, 32'hf);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge clk_in);
    // Receive that never gets a reply: three tries of fifty milliseconds.
    wr(`UDSP_B_SEG + 12'h40, 32'h00550000);
    wr(`UDSP_B_PCFG + 12'h1, 32'h00010000);
    wr(`UDSP_B_CMD + 12'h4, 32'h00000a21);
    wr(`UDSP_B_CMD + 12'h5, 32'h00000002);
    wr(`UDSP_B_CMD + 12'h6, 32'h00320000);
    wr(`UDSP_B_GRP, 32'h1);
    run(n);
    chk({31'h0, n >= 1400 && n <= 1700}, 32'h1);
    rd(`UDSP_A_ISTAT, v); chk(v & 32'he, 32'he);
    wr(`UDSP_A_ISTAT, 32'hf);
    // Receive whose second byte is written into data register one.
    wr(`UDSP_B_DREG + 12'h1, 32'h0);
    wr(`UDSP_B_SEG + 12'h80, 32'h00550000);
    wr(`UDSP_B_SEG + 12'h81, 32'h01000030);
    wr(`UDSP_B_PCFG + 12'h2, 32'h00020000);
    wr(`UDSP_B_CMD + 12'h8, 32'h00000241);
    wr(`UDSP_B_CMD + 12'h9, 32'h0);
    wr(`UDSP_B_CMD + 12'ha, 32'h00320000);
    wr(`UDSP_B_GRP, 32'h2);
    fork
      run(n);
      begin
        repeat (8) @(posedge clk_in);
        m.rsp_q = '{8'h55, 8'hc3};
      end
    join
    rd(`UDSP_B_DREG + 12'h1, v); chk(v, 32'hc3);
    rd(`UDSP_A_ISTAT, v); chk(v & 32'h1, 32'h1);
    // Send of ASCII length digits, hex and ASCII conversions and their zero cases.
    wr(`UDSP_B_DREG + 12'h2, 32'h42);
    wr(`UDSP_B_DREG + 12'h3, 32'h0c);
    wr(`UDSP_B_SEG + 12'hc0, 32'h0035008a);
    wr(`UDSP_B_SEG + 12'hc1, 32'h02000014);
    wr(`UDSP_B_SEG + 12'hc2, 32'h03000018);
    wr(`UDSP_B_SEG + 12'hc3, 32'h03000014);
    wr(`UDSP_B_SEG + 12'hc4, 32'h02000018);
    wr(`UDSP_B_PCFG + 12'h3, 32'h00050000);
    wr(`UDSP_B_CMD + 12'hc, 32'h0000020c);
    wr(`UDSP_B_CMD + 12'hd, 32'h0);
    wr(`UDSP_B_CMD + 12'he, 32'h00320000);
    wr(`UDSP_B_GRP, 32'h3);
    run(n);
    chk(m.got_q.size(), 32'd16);
    for (int i = 0; i < 6; i++) chk({24'h0, m.got_q[10 + i]}, {24'h0, exp_c[i]});
    report_and_stop();
  end
endmodule : udsp_seq_test
